//--- accum_arith_defines.vh
`ifndef ACCUM_ARITH_DEFINES_VH
`define ACCUM_ARITH_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CMD        8'h00
`define REG_ADDR       8'h04
`define REG_CONST      8'h08
`define REG_ACC        8'h0C
`define REG_FLAGS      8'h10
`define REG_MEM_INDEX  8'h14
`define REG_MEM_DATA   8'h18

// ****************************************
// Command fields and codes
// ****************************************
`define CMD_OP_MSB     3
`define CMD_SRC_MSB    5
`define CMD_SRC_LSB    4
`define OP_REAL_DIVIDE 4'h1
`define OP_BCD_ADD_ONE 4'h2
`define OP_BCD_SUB_ONE 4'h3
`define OP_ADD_16      4'h4
`define OP_ADD_32      4'h5
`define OP_MINUS_16    4'h6
`define OP_MINUS_32    4'h7
`define SRC_DIRECT     2'h0
`define SRC_POINTER    2'h1
`define SRC_CONST      2'h2

// ****************************************
// Flag bit positions and accumulator reset value
// ****************************************
`define FLG_ZERO       0
`define FLG_NEGATIVE   1
`define FLG_CARRY_16   2
`define FLG_CARRY_32   3
`define FLG_BORROW_16  4
`define FLG_BORROW_32  5
`define FLG_SIGN_ERR   6
`define FLG_BAD_PTR    7
`define FLG_BAD_FLOAT  8
`define FLG_UNDERFLOW  9
`define FLG_BAD_OPND   10
`define FLG_WIDTH      11
`define ACC_RESET      32'h0000_0000

// ****************************************
// Single-precision constants
// ****************************************
`define FLT_QNAN       32'h7FC0_0000
`define FLT_EXP_MAX    8'hFF
`define FLT_BIAS       10'h07F
`define FLT_LAST_STEP  5'h18

`endif

//--- real_divider.v
`timescale 1ns/1ps
`include "accum_arith_defines.vh"

module real_divider (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Request
    input  wire        start,
    input  wire [31:0] dividend,
    input  wire [31:0] divisor,
    // Answer
    output reg         done,
    output reg  [31:0] quotient,
    output reg         bad_float,
    output reg         underflow,
    output reg         bad_operand
);

    reg        busy;
    reg        finish;
    reg  [4:0] step;
    reg [24:0] rem;
    reg [23:0] div_m;
    reg [24:0] qbits;
    reg        sign;
    reg  [9:0] exp_s;

    wire [7:0]  exp_a   = dividend[30:23];
    wire [7:0]  exp_b   = divisor[30:23];
    wire        nonreal = (exp_a == `FLT_EXP_MAX) || (exp_b == `FLT_EXP_MAX);
    wire [24:0] diff    = rem - {1'b0, div_m};
    wire        fits    = (rem >= {1'b0, div_m});
    wire        norm    = qbits[24];
    wire [22:0] frac    = norm ? qbits[23:1] : qbits[22:0];
    wire  [9:0] exp_n   = norm ? exp_s : exp_s - 10'h001;

    // ****************************************
    // Restoring mantissa division
    // ****************************************
    // Truncates instead of rounding; denormals are taken as zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy        <= 1'b0;
            finish      <= 1'b0;
            step        <= 5'h00;
            rem         <= 25'h0000000;
            div_m       <= 24'h000000;
            qbits       <= 25'h0000000;
            sign        <= 1'b0;
            exp_s       <= 10'h000;
            done        <= 1'b0;
            quotient    <= 32'h0000_0000;
            bad_float   <= 1'b0;
            underflow   <= 1'b0;
            bad_operand <= 1'b0;
        end else begin
            done   <= 1'b0;
            finish <= 1'b0;
            if (start) begin
                sign        <= dividend[31] ^ divisor[31];
                bad_float   <= 1'b0;
                underflow   <= 1'b0;
                bad_operand <= 1'b0;
                if (nonreal) begin
                    done        <= 1'b1;
                    quotient    <= `FLT_QNAN;
                    bad_operand <= 1'b1;
                    bad_float   <= 1'b1;
                end else if (exp_b == 8'h00) begin
                    done      <= 1'b1;
                    quotient  <= {dividend[31] ^ divisor[31],
                                  `FLT_EXP_MAX, 23'h000000};
                    bad_float <= 1'b1;
                end else if (exp_a == 8'h00) begin
                    done     <= 1'b1;
                    quotient <= {dividend[31] ^ divisor[31], 31'h00000000};
                end else begin
                    busy  <= 1'b1;
                    step  <= 5'h00;
                    rem   <= {2'b01, dividend[22:0]};
                    div_m <= {1'b1, divisor[22:0]};
                    exp_s <= {2'b00, exp_a} - {2'b00, exp_b} + `FLT_BIAS;
                end
            end else if (busy) begin
                qbits <= {qbits[23:0], fits};
                rem   <= fits ? {diff[23:0], 1'b0} : {rem[23:0], 1'b0};
                step  <= step + 5'h01;
                if (step == `FLT_LAST_STEP) begin
                    busy   <= 1'b0;
                    finish <= 1'b1;
                end
            end else if (finish) begin
                done <= 1'b1;
                if (exp_n[9] || exp_n == 10'h000) begin
                    quotient  <= {sign, 31'h00000000};
                    underflow <= 1'b1;
                end else if (exp_n >= {2'b00, `FLT_EXP_MAX}) begin
                    quotient  <= {sign, `FLT_EXP_MAX, 23'h000000};
                    bad_float <= 1'b1;
                end else begin
                    quotient <= {sign, exp_n[7:0], frac};
                end
            end
        end
    end

endmodule // real_divider

//--- accumulator_arith_flags.v
`timescale 1ns/1ps
`include "accum_arith_defines.vh"

module accumulator_arith_flags #(
    parameter MEM_WORDS = 16,
    parameter ADDR_BITS = 4
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp
);

    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_DIV  = 2'h2;
    localparam [15:0] LAST_WORD = MEM_WORDS - 1;

    // ****************************************
    // State
    // ****************************************
    reg  [1:0]            state;
    reg  [3:0]            opcode;
    reg  [1:0]            source;
    reg  [ADDR_BITS-1:0]  op_addr;
    reg  [31:0]           const_val;
    reg  [31:0]           acc;
    reg  [`FLG_WIDTH-1:0] flags;
    reg  [ADDR_BITS-1:0]  mem_index;
    reg  [15:0]           mem [0:MEM_WORDS-1];
    reg                   data_phase;
    reg  [7:0]            d_addr;
    reg                   d_write;
    reg                   div_start;
    reg  [31:0]           div_divisor;

    wire                  div_done;
    wire [31:0]           div_quotient;
    wire                  div_bad_float;
    wire                  div_underflow;
    wire                  div_bad_operand;

    integer i;

    // ****************************************
    // Operand fetch
    // ****************************************
    wire [15:0]          ptr_word = mem[op_addr];
    wire                 ptr_bad  = (source == `SRC_POINTER) &&
                                    (ptr_word > LAST_WORD);
    wire [ADDR_BITS-1:0] eff_addr = (source == `SRC_POINTER) ?
                                    ptr_word[ADDR_BITS-1:0] : op_addr;
    wire [15:0]          lo_word  = mem[eff_addr];
    wire [15:0]          hi_word  = mem[eff_addr + 1'b1];
    wire                 use_k    = (source == `SRC_CONST);
    wire [15:0]          opnd16   = use_k ? const_val[15:0] : lo_word;
    wire [31:0]          opnd32   = use_k ? const_val : {hi_word, lo_word};

    // ****************************************
    // Binary add and subtract
    // ****************************************
    wire [31:0] addend   = (opcode == `OP_ADD_16) ? {16'h0000, opnd16} :
                           opnd32;
    wire [31:0] aug      = (opcode == `OP_ADD_16) ? {16'h0000, acc[15:0]} :
                           acc;
    wire [32:0] sum      = {1'b0, aug} + {1'b0, addend};
    wire [16:0] sum_lo   = {1'b0, aug[15:0]} + {1'b0, addend[15:0]};
    wire        sum_ovf  = (aug[31] == addend[31]) &&
                           (sum[31] != aug[31]);
    wire [31:0] subtr    = (opcode == `OP_MINUS_16) ? {16'h0000, opnd16} :
                           opnd32;
    wire [31:0] dif      = acc - subtr;
    wire        brw_lo   = acc[15:0] < subtr[15:0];
    wire        brw_full = acc < subtr;

    // ****************************************
    // BCD add one and subtract one
    // ****************************************
    wire [3:0]  digit_bad;
    wire [4:0]  inc_carry;
    wire [4:0]  dec_borrow;
    wire [15:0] bcd_inc;
    wire [15:0] bcd_dec;

    assign inc_carry[0]  = 1'b1;
    assign dec_borrow[0] = 1'b1;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_digit
            wire [3:0] d = eff_digit(lo_word, g);
            assign digit_bad[g] = (d > 4'h9);
            assign inc_carry[g+1] = inc_carry[g] && (d == 4'h9);
            assign dec_borrow[g+1] = dec_borrow[g] && (d == 4'h0);
            assign bcd_inc[4*g+3:4*g] = !inc_carry[g] ? d :
                                        (d == 4'h9) ? 4'h0 : d + 4'h1;
            assign bcd_dec[4*g+3:4*g] = !dec_borrow[g] ? d :
                                        (d == 4'h0) ? 4'h9 : d - 4'h1;
        end
    endgenerate

    function [3:0] eff_digit;
        input [15:0] w;
        input integer n;
        begin
            eff_digit = w[n*4 +: 4];
        end
    endfunction

    wire        bcd_bad    = |digit_bad;
    wire [15:0] bcd_result = (opcode == `OP_BCD_ADD_ONE) ? bcd_inc :
                             bcd_dec;

    // ****************************************
    // Bus decode
    // ****************************************
    wire addr_phase = hsel && htrans[1] && hready;
    wire bus_wr     = data_phase && d_write && (state == ST_IDLE);
    wire cmd_wr     = bus_wr && (d_addr == `REG_CMD);

    // ****************************************
    // Real divider
    // ****************************************
    real_divider u_real_divider (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .start       (div_start),
        .dividend    (acc),
        .divisor     (div_divisor),
        .done        (div_done),
        .quotient    (div_quotient),
        .bad_float   (div_bad_float),
        .underflow   (div_underflow),
        .bad_operand (div_bad_operand)
    );

    // ****************************************
    // Instruction sequencing, accumulator, flags
    // ****************************************
    // Each instruction rewrites only the flags it owns; the rest hold.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= ST_IDLE;
            opcode      <= 4'h0;
            source      <= `SRC_DIRECT;
            op_addr     <= {ADDR_BITS{1'b0}};
            const_val   <= 32'h0000_0000;
            acc         <= `ACC_RESET;
            flags       <= {`FLG_WIDTH{1'b0}};
            mem_index   <= {ADDR_BITS{1'b0}};
            div_start   <= 1'b0;
            div_divisor <= 32'h0000_0000;
        end else begin
            div_start <= 1'b0;
            if (bus_wr) begin
                case (d_addr)
                    `REG_CMD: begin
                        opcode <= hwdata[`CMD_OP_MSB:0];
                        source <= hwdata[`CMD_SRC_MSB:`CMD_SRC_LSB];
                        state  <= ST_EXEC;
                    end
                    `REG_ADDR:      op_addr   <= hwdata[ADDR_BITS-1:0];
                    `REG_CONST:     const_val <= hwdata;
                    `REG_ACC:       acc       <= hwdata;
                    `REG_MEM_INDEX: mem_index <= hwdata[ADDR_BITS-1:0];
                    default: ;
                endcase
            end
            case (state)
                ST_EXEC: begin
                    state <= ST_IDLE;
                    case (opcode)
                        `OP_REAL_DIVIDE: begin
                            flags[`FLG_BAD_PTR] <= ptr_bad;
                            if (!ptr_bad) begin
                                div_divisor <= opnd32;
                                div_start   <= 1'b1;
                                state       <= ST_DIV;
                            end
                        end
                        `OP_BCD_ADD_ONE, `OP_BCD_SUB_ONE: begin
                            flags[`FLG_BAD_OPND] <= bcd_bad;
                            flags[`FLG_ZERO] <= !bcd_bad &&
                                (bcd_result == 16'h0000);
                        end
                        `OP_ADD_16, `OP_ADD_32: begin
                            acc <= sum[31:0];
                            flags[`FLG_ZERO] <= (sum[31:0] == 32'h0);
                            flags[`FLG_NEGATIVE] <= sum[31];
                            flags[`FLG_CARRY_16] <= (opcode == `OP_ADD_16)
                                ? sum[16] : sum_lo[16];
                            flags[`FLG_CARRY_32] <= sum[32];
                            flags[`FLG_SIGN_ERR] <= sum_ovf;
                        end
                        `OP_MINUS_16, `OP_MINUS_32: begin
                            acc <= dif;
                            flags[`FLG_ZERO] <= (dif == 32'h0);
                            flags[`FLG_NEGATIVE] <= dif[31];
                            flags[`FLG_BORROW_16] <= brw_lo;
                            flags[`FLG_BORROW_32] <= brw_full;
                        end
                        default: ;
                    endcase
                end
                ST_DIV: begin
                    if (div_done) begin
                        state <= ST_IDLE;
                        acc   <= div_quotient;
                        flags[`FLG_ZERO] <=
                            (div_quotient[30:0] == 31'h0);
                        flags[`FLG_NEGATIVE] <= div_quotient[31];
                        // Quotient sign is exact, so no sign error.
                        flags[`FLG_SIGN_ERR]  <= 1'b0;
                        flags[`FLG_BAD_FLOAT] <= div_bad_float;
                        flags[`FLG_UNDERFLOW] <= div_underflow;
                        flags[`FLG_BAD_OPND]  <= div_bad_operand;
                    end
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // Data memory
    // ****************************************
    // Non-BCD words are left untouched, only the flag reports them.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < MEM_WORDS; i = i + 1) begin
                mem[i] <= 16'h0000;
            end
        end else if (state == ST_EXEC &&
                     (opcode == `OP_BCD_ADD_ONE ||
                      opcode == `OP_BCD_SUB_ONE) && !bcd_bad) begin
            mem[eff_addr] <= bcd_result;
        end else if (bus_wr && d_addr == `REG_MEM_DATA) begin
            mem[mem_index] <= hwdata[15:0];
        end
    end

    // ****************************************
    // AHB-Lite slave, one wait state per transfer
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_phase <= 1'b0;
            d_addr     <= 8'h00;
            d_write    <= 1'b0;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (data_phase) begin
                data_phase <= 1'b0;
                hreadyout  <= 1'b1;
                if (!d_write) begin
                    case (d_addr)
                        `REG_CMD:
                            hrdata <= {31'h0, state != ST_IDLE};
                        `REG_ADDR:
                            hrdata <= {{(32-ADDR_BITS){1'b0}}, op_addr};
                        `REG_CONST:     hrdata <= const_val;
                        `REG_ACC:       hrdata <= acc;
                        `REG_FLAGS:
                            hrdata <= {{(32-`FLG_WIDTH){1'b0}}, flags};
                        `REG_MEM_INDEX:
                            hrdata <= {{(32-ADDR_BITS){1'b0}}, mem_index};
                        `REG_MEM_DATA:
                            hrdata <= {16'h0000, mem[mem_index]};
                        default:        hrdata <= 32'h0000_0000;
                    endcase
                end
            end else if (addr_phase) begin
                data_phase <= 1'b1;
                d_addr     <= haddr[7:0];
                d_write    <= hwrite;
                hreadyout  <= 1'b0;
            end
        end
    end

endmodule // accumulator_arith_flags

//--- seq_bus.sv
`timescale 1ns/1ps
module seq_bus (
    // Clock and bus answer
    input  wire         hclk,
    input  wire         hready,
    input  wire  [31:0] hrdata,
    // Bus request
    output logic        hsel,
    output logic [31:0] haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata,
    // Checked read results
    output logic [31:0] rd_val,
    output logic [31:0] rd_cnt
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_val = 32'h0;
        rd_cnt = 32'h0;
    end

    // Stale address and data are inverted so a late sampler cannot win
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic c,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~{24'h0, a};
        hwdata <= w ? d : ~d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
        hwdata <= ~d;
        if (c) begin
            rd_val <= hrdata;
            rd_cnt <= rd_cnt + 32'h1;
        end
    endtask
endmodule // seq_bus

//--- arith_monitor.sv
`timescale 1ns/1ps
`include "accum_arith_defines.vh"
module arith_monitor (
    // Clock and reset
    input wire        hclk,
    input wire        hresetn,
    // Bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp
);
    logic        act, wph, clean, acc_ok, flg_ok;
    logic [7:0]  adr;
    logic [3:0]  op;
    logic [31:0] accv, flgv;
    wire take = hsel & htrans[1] & hready;
    wire done = act & hreadyout;
    wire rd_acc = done & !wph & (adr == `REG_ACC);
    wire rd_flg = done & !wph & (adr == `REG_FLAGS);
    wire wr_cmd = done & wph & (adr == `REG_CMD);
    // Only judge add/sub flags when nothing but the command was written
    wire arith = clean & acc_ok & (op[3:2] == 2'h1);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act <= 1'b0;
            wph <= 1'b0;
            adr <= 8'h0;
            op <= 4'h0;
            clean <= 1'b0;
            acc_ok <= 1'b0;
            flg_ok <= 1'b0;
            accv <= 32'h0;
            flgv <= 32'h0;
        end else begin
            if (done) act <= 1'b0;
            if (take) begin
                act <= 1'b1;
                adr <= haddr[7:0];
                wph <= hwrite;
            end
            if (wr_cmd) begin
                op <= hwdata[3:0];
                clean <= 1'b1;
                acc_ok <= 1'b0;
                flg_ok <= 1'b0;
            end else if (done & wph) begin
                clean <= 1'b0;
                acc_ok <= 1'b0;
            end
            if (rd_acc) begin
                accv <= hrdata;
                acc_ok <= clean;
            end
            if (rd_flg) begin
                flgv <= hrdata;
                flg_ok <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    okay_resp_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("wait state not one cycle");
    zero_flag_a: assert property (
        rd_flg && arith |-> hrdata[0] == (accv == 32'h0))
        else $error("zero flag wrong");
    neg_flag_a: assert property (
        rd_flg && arith |-> hrdata[1] == accv[31])
        else $error("negative flag wrong");
    carry_low_a: assert property (
        rd_flg && arith && op == 4'h4 |-> hrdata[2] == accv[16])
        else $error("carry 16 wrong");
    carry_high_a: assert property (
        rd_flg && clean && op == 4'h4 |-> !hrdata[3])
        else $error("carry 32 after add16");
    add16_width_a: assert property (
        rd_acc && clean && op == 4'h4 |-> hrdata[31:17] == 15'h0)
        else $error("add16 result too wide");
    flags_hold_a: assert property (
        rd_flg && flg_ok |-> hrdata == flgv)
        else $error("flags changed without instruction");

    cover property (wr_cmd && hwdata[3:0] == 4'h1);
    cover property (rd_flg && arith);
    cover property (rd_flg && flg_ok);
endmodule // arith_monitor

bind accumulator_arith_flags arith_monitor arith_monitor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

//--- testbench.sv
`timescale 1ns/1ps
`include "accum_arith_defines.vh"
module testbench;
    logic        hclk;
    logic        hresetn;
    wire         hsel, hwrite, hreadyout, hresp;
    wire [1:0]   htrans;
    wire [2:0]   hsize;
    wire [31:0]  haddr, hwdata, hrdata, rd_val, rd_cnt;
    int          mismatches, check_count, seed, i;
    logic [31:0] exp_q[$];
    string       nam_q[$];
    logic [31:0] acc;
    logic [10:0] flg;

    accumulator_arith_flags accumulator_arith_flags_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    seq_bus seq_bus_inst (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .rd_val(rd_val), .rd_cnt(rd_cnt));

    // ****************************************
    // Checking
    // ****************************************
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask

    always @(rd_cnt) begin
        if (exp_q.size() > 0)
            chk(nam_q.pop_front(), rd_val, exp_q.pop_front());
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // Bus and instruction tasks
    // ****************************************
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        seq_bus_inst.xfer(1'b1, a, d, 1'b0, r);
    endtask

    task rd(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        exp_q.push_back(x);
        nam_q.push_back(n);
        seq_bus_inst.xfer(1'b0, a, 32'h0, 1'b1, r);
    endtask

    task memw(input logic [3:0] k, input logic [15:0] d);
        wr(`REG_MEM_INDEX, {28'h0, k});
        wr(`REG_MEM_DATA, {16'h0, d});
    endtask

    // Results are only read once busy has dropped
    task run(input logic [3:0] op, input logic [1:0] src);
        logic [31:0] r;
        wr(`REG_CMD, {26'h0, src, op});
        r = 32'h1;
        while (r[0] === 1'b1)
            seq_bus_inst.xfer(1'b0, `REG_CMD, 32'h0, 1'b0, r);
    endtask

    task bin(input logic [3:0] op, input logic [1:0] src,
             input logic [31:0] x, input logic [31:0] y);
        logic [32:0] s;
        logic [16:0] l;
        wr(`REG_ACC, x);
        if (src == `SRC_CONST) wr(`REG_CONST, y);
        else begin
            // Operand pair at 15 and 0 checks the index wrap
            memw(4'hF, y[15:0]);
            memw(4'h0, y[31:16]);
            wr(`REG_ADDR, src == `SRC_DIRECT ? 32'hF : 32'h2);
            if (src == `SRC_POINTER) memw(4'h2, 16'h000F);
        end
        run(op, src);
        if (!op[0]) y = {16'h0, y[15:0]};
        if (op == 4'h4) x = {16'h0, x[15:0]};
        l = {1'b0, x[15:0]} + {1'b0, y[15:0]};
        s = op[1] ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
        acc = s[31:0];
        if (op[1]) begin
            flg[4] = x[15:0] < y[15:0];
            flg[5] = x < y;
        end else begin
            flg[2] = l[16];
            flg[3] = s[32];
            flg[6] = x[31] == y[31] && s[31] != x[31];
        end
        flg[0] = acc == 32'h0;
        flg[1] = acc[31];
        rd("acc", `REG_ACC, acc);
        rd("flags", `REG_FLAGS, {21'h0, flg});
    endtask

    task bcd(input logic [3:0] op, input logic [15:0] w,
             input logic [15:0] x, input logic bad);
        memw(4'h5, w);
        wr(`REG_ADDR, 32'h5);
        run(op, `SRC_DIRECT);
        flg[0] = !bad && x == 16'h0;
        flg[10] = bad;
        rd("word", `REG_MEM_DATA, {16'h0, x});
        rd("flags", `REG_FLAGS, {21'h0, flg});
    endtask

    task dvd(input logic [31:0] x, input logic [31:0] y,
             input logic [31:0] q, input logic [2:0] f);
        wr(`REG_ACC, x);
        wr(`REG_CONST, y);
        run(`OP_REAL_DIVIDE, `SRC_CONST);
        acc = q;
        flg[0] = q[30:0] == 31'h0;
        flg[1] = q[31];
        flg[7:6] = 2'h0;
        flg[10:8] = f;
        rd("acc", `REG_ACC, acc);
        rd("flags", `REG_FLAGS, {21'h0, flg});
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    initial begin
        #60000;
        mismatches++;
        report_and_stop;
    end

    initial begin
        hresetn = 1'b0;
        seed = 69730;
        flg = 11'h0;
        mismatches = 0;
        check_count = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bin(4'h4, `SRC_CONST, 32'h1234FFFF, 32'hABCD0001);
        bin(4'h4, `SRC_DIRECT, 32'hFFFF0000, 32'h00000000);
        bin(4'h5, `SRC_POINTER, 32'hFFFFFFFF, 32'h00000001);
        bin(4'h5, `SRC_CONST, 32'h7FFFFFFF, 32'h00000001);
        bin(4'h6, `SRC_DIRECT, 32'h00010000, 32'h00000001);
        bin(4'h7, `SRC_POINTER, 32'h00000001, 32'h00000002);
        for (i = 0; i < 12; i++)
            bin(4'(4 + i % 4), 2'(i % 3), $random(seed), $random(seed));
        $display("test add_sub done");
        bcd(`OP_BCD_ADD_ONE, 16'h0199, 16'h0200, 1'b0);
        bcd(`OP_BCD_ADD_ONE, 16'h9999, 16'h0000, 1'b0);
        bcd(`OP_BCD_SUB_ONE, 16'h0000, 16'h9999, 1'b0);
        bcd(`OP_BCD_SUB_ONE, 16'h1000, 16'h0999, 1'b0);
        bcd(`OP_BCD_ADD_ONE, 16'h12A4, 16'h12A4, 1'b1);
        $display("test bcd done");
        dvd(32'h40C00000, 32'h40000000, 32'h40400000, 3'h0);
        dvd(32'hC0C00000, 32'h40000000, 32'hC0400000, 3'h0);
        dvd(32'h7F7FFFFF, 32'h7F7FFFFF, 32'h3F800000, 3'h0);
        dvd(32'h00800000, 32'h40000000, 32'h00000000, 3'h2);
        dvd(32'h40000000, 32'h7F800001, 32'h7FC00000, 3'h5);
        dvd(32'h3F800000, 32'h00000000, 32'h7F800000, 3'h1);
        memw(4'h2, 16'h0010);
        wr(`REG_ADDR, 32'h2);
        run(`OP_REAL_DIVIDE, `SRC_POINTER);
        flg[7] = 1'b1;
        rd("acc", `REG_ACC, acc);
        rd("flags", `REG_FLAGS, {21'h0, flg});
        $display("test divide done");
        wr(8'h40, $random(seed));
        wr(`REG_ACC, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        rd("flags", `REG_FLAGS, {21'h0, flg});
        $display("test hold done");
        @(posedge hclk);
        report_and_stop;
    end
endmodule // testbench
